// file: hw/tmr8_timer.sv
/*
 8-bit timer with two compare channels, waveform modes, force strobes,
 clock selection and match/overflow flags behind a plain register port.
 Assumes register strobes and the external count input are synchronous
 to clock_in, and that port direction bits come from outside.
*/
`include "tmr8_consts.svh"
module tmr8_timer (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic ext_count_in,
    input wire logic global_irq_enable_in,
    input wire logic [2:0] irq_ack_in,
    input wire logic [1:0] chan_dir_in,
    output logic chan_a_wave_out,
    output logic chan_b_wave_out,
    output logic [1:0] chan_pin_own_out,
    output logic [1:0] chan_pin_oe_out,
    output logic [2:0] irq_out
);
    logic [1:0][1:0] com;
    logic [2:0] wgm;
    logic [2:0] cs;
    logic [7:0] cnt;
    logic [1:0][7:0] ocr_sw;
    logic [1:0][7:0] ocr_act;
    logic [2:0] mask;
    logic [2:0] flags;
    logic down;
    logic blocked;
    logic ext_prev;
    logic [1:0] wave;
    logic [1:0] own;
    logic [1:0] oe;
    logic [2:0] irq;
    logic [7:0] rdata;
    logic [7:0] next_cnt;
    logic next_down;
    logic [1:0] next_wave;

    tmr8_pkg::tmr8_wave_class_type cls;

    tmr8_tick_if tick_bus ();

    tmr8_prescaler u_prescaler (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .tick_bus(tick_bus.src)
    );

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (srst_in);

    // Register port decode
    wire wr_ctl_a = reg_wr_in && (reg_addr_in == `TMR8_ADDR_CTL_A);
    wire wr_ctl_b = reg_wr_in && (reg_addr_in == `TMR8_ADDR_CTL_B);
    wire cnt_wr = reg_wr_in && (reg_addr_in == `TMR8_ADDR_COUNT);
    wire wr_cmp_a = reg_wr_in && (reg_addr_in == `TMR8_ADDR_CMP_A);
    wire wr_cmp_b = reg_wr_in && (reg_addr_in == `TMR8_ADDR_CMP_B);
    wire wr_mask = reg_wr_in && (reg_addr_in == `TMR8_ADDR_MASK);
    wire wr_flags = reg_wr_in && (reg_addr_in == `TMR8_ADDR_FLAGS);

    // Mode family: low bit clear is non-PWM, then fast or phase-correct
    assign cls = !wgm[0] ? tmr8_pkg::TMR8_WAVE_NONPWM :
                 (wgm[1] ? tmr8_pkg::TMR8_WAVE_FAST : tmr8_pkg::TMR8_WAVE_PHASE);
    wire non_pwm = (cls == tmr8_pkg::TMR8_WAVE_NONPWM);
    wire phase = (cls == tmr8_pkg::TMR8_WAVE_PHASE);

    // TOP source: compare A in modes 2, 5 and 7, else the fixed maximum
    wire top_from_a = (wgm == `TMR8_MODE_CTC) || (wgm == `TMR8_MODE_PC_A) ||
                      (wgm == `TMR8_MODE_FAST_A);
    wire [7:0] top = top_from_a ? ocr_act[0] : `TMR8_MAX;
    wire at_top = (cnt == top);
    wire at_bottom = (cnt == `TMR8_BOTTOM);

    // Count clock selection, external edges counted regardless of direction
    wire ext_fall = ext_prev && !ext_count_in;
    wire ext_rise = !ext_prev && ext_count_in;
    wire tick = (cs == `TMR8_CS_DIRECT) ||
                ((cs == `TMR8_CS_DIV8) && tick_bus.tap[0]) ||
                ((cs == `TMR8_CS_DIV64) && tick_bus.tap[1]) ||
                ((cs == `TMR8_CS_DIV256) && tick_bus.tap[2]) ||
                ((cs == `TMR8_CS_DIV1024) && tick_bus.tap[3]) ||
                ((cs == `TMR8_CS_EXT_FALL) && ext_fall) ||
                ((cs == `TMR8_CS_EXT_RISE) && ext_rise);
    wire adv = tick && !cnt_wr;

    // Overflow point: bottom in phase-correct, TOP in mode 7, else maximum
    wire ovf_ev = adv && (phase ? at_bottom :
                  ((wgm == `TMR8_MODE_FAST_A) ? at_top : (cnt == `TMR8_MAX)));

    // Compare buffers load at once in non-PWM, at TOP or wrap in PWM
    wire ocr_upd = non_pwm || (adv && at_top);
    wire bot_ev = adv && at_top && !phase;
    wire top_ev = adv && at_top && phase;
    wire match_down = down && !at_bottom;

    // Per-channel compare, force and special-case decode
    wire [1:0] match;
    wire [1:0] eq_top;
    wire [1:0] force_st;
    wire [1:0] tgl_ok;
    for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
        assign match[ch] = adv && !blocked && (cnt == ocr_act[ch]);
        assign eq_top[ch] = (ocr_act[ch] == top);
    end
    assign force_st[0] = wr_ctl_b && reg_wdata_in[`TMR8_FORCE_A_BIT];
    assign force_st[1] = wr_ctl_b && reg_wdata_in[`TMR8_FORCE_B_BIT];
    assign tgl_ok[0] = wgm[2];
    assign tgl_ok[1] = 1'b0;

    // Output action of one channel for its action field and mode family
    function automatic logic wave_step(
        input tmr8_pkg::tmr8_wave_class_type fam,
        input logic [1:0] act,
        input logic cur,
        input logic hit,
        input logic frc,
        input logic bot,
        input logic tp,
        input logic eqt,
        input logic dn,
        input logic tok
    );
        logic r;
        r = cur;
        unique case (fam)
            tmr8_pkg::TMR8_WAVE_NONPWM: begin
                if (hit || frc) begin
                    if (act == 2'h1) begin
                        r = !cur;
                    end else if (act[1]) begin
                        r = act[0];
                    end
                end
            end
            tmr8_pkg::TMR8_WAVE_FAST: begin
                if (act == 2'h1) begin
                    r = (tok && hit) ? !cur : cur;
                end else if (act[1]) begin
                    if (hit && !eqt) begin
                        r = act[0];
                    end else if (bot) begin
                        r = !act[0];
                    end
                end
            end
            tmr8_pkg::TMR8_WAVE_PHASE: begin
                if (act == 2'h1) begin
                    r = (tok && hit) ? !cur : cur;
                end else if (act[1]) begin
                    if (hit && !eqt) begin
                        r = dn ? !act[0] : act[0];
                    end else if (tp && eqt) begin
                        r = !act[0];
                    end
                end
            end
        endcase
        return r;
    endfunction

    // Waveform registers, force ignored outside non-PWM modes
    for (genvar ch = 0; ch < 2; ch++) begin : g_wave
        assign next_wave[ch] = wave_step(cls, com[ch], wave[ch], match[ch],
                                         force_st[ch] && non_pwm,
                                         bot_ev, top_ev, eq_top[ch], match_down,
                                         tgl_ok[ch]);
        always_ff @(posedge clock_in) begin
            if (srst_in) begin
                wave[ch] <= 1'b0;
                own[ch] <= 1'b0;
                oe[ch] <= 1'b0;
            end else begin
                wave[ch] <= next_wave[ch];
                own[ch] <= |com[ch];
                oe[ch] <= (|com[ch]) && chan_dir_in[ch];
            end
        end
    end

    // Counter sequence: single slope wraps at TOP, dual slope turns at ends
    always_comb begin
        next_cnt = cnt;
        next_down = phase ? down : 1'b0;
        if (cnt_wr) begin
            next_cnt = reg_wdata_in;
        end else if (tick) begin
            if (phase) begin
                if (!down && at_top) begin
                    next_cnt = cnt - 8'h01;
                    next_down = 1'b1;
                end else if (down && at_bottom) begin
                    next_cnt = cnt + 8'h01;
                    next_down = 1'b0;
                end else if (down) begin
                    next_cnt = cnt - 8'h01;
                end else begin
                    next_cnt = cnt + 8'h01;
                end
            end else if (at_top) begin
                next_cnt = `TMR8_BOTTOM;
            end else begin
                next_cnt = cnt + 8'h01;
            end
        end
    end

    // Flag update: hardware set wins over write-one and vector clears
    wire [2:0] flag_set = {match[1], match[0], ovf_ev};
    wire [2:0] flag_clr = irq_ack_in | (wr_flags ? reg_wdata_in[2:0] : 3'h0);
    wire [2:0] next_flags = (flags & ~flag_clr) | flag_set;

    // Read multiplexer; reserved and strobe bits read zero
    wire [7:0] rd_mux =
        (reg_addr_in == `TMR8_ADDR_CTL_A) ? {com[0], com[1], 2'h0, wgm[1:0]} :
        (reg_addr_in == `TMR8_ADDR_CTL_B) ? {4'h0, wgm[2], cs} :
        (reg_addr_in == `TMR8_ADDR_COUNT) ? cnt :
        (reg_addr_in == `TMR8_ADDR_CMP_A) ? ocr_sw[0] :
        (reg_addr_in == `TMR8_ADDR_CMP_B) ? ocr_sw[1] :
        (reg_addr_in == `TMR8_ADDR_MASK) ? {5'h00, mask} :
        (reg_addr_in == `TMR8_ADDR_FLAGS) ? {5'h00, flags} : 8'h00;

    // Control registers
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            com <= '0;
            wgm <= 3'h0;
            cs <= `TMR8_CS_STOP;
        end else begin
            if (wr_ctl_a) begin
                com[0] <= reg_wdata_in[`TMR8_COM_A_LSB +: 2];
                com[1] <= reg_wdata_in[`TMR8_COM_B_LSB +: 2];
                wgm[1:0] <= reg_wdata_in[1:0];
            end
            if (wr_ctl_b) begin
                wgm[2] <= reg_wdata_in[`TMR8_WGM_HI_BIT];
                cs <= reg_wdata_in[2:0];
            end
        end
    end

    // Compare registers: software copy and active copy
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ocr_sw <= {2{`TMR8_RESET_BYTE}};
            ocr_act <= {2{`TMR8_RESET_BYTE}};
        end else begin
            if (wr_cmp_a) begin
                ocr_sw[0] <= reg_wdata_in;
            end
            if (wr_cmp_b) begin
                ocr_sw[1] <= reg_wdata_in;
            end
            if (ocr_upd) begin
                ocr_act <= ocr_sw;
            end
        end
    end

    // Counter, direction, match blocking and edge history
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cnt <= `TMR8_RESET_BYTE;
            down <= 1'b0;
            blocked <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            cnt <= next_cnt;
            down <= next_down;
            blocked <= cnt_wr || (blocked && !tick);
            ext_prev <= ext_count_in;
        end
    end

    // Mask, flags, interrupt lines and read data
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            mask <= 3'h0;
            flags <= 3'h0;
            irq <= 3'h0;
            rdata <= 8'h00;
        end else begin
            if (wr_mask) begin
                mask <= reg_wdata_in[2:0];
            end
            flags <= next_flags;
            irq <= flags & mask & {3{global_irq_enable_in}};
            rdata <= reg_rd_in ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata_out = rdata;
    assign chan_a_wave_out = wave[0];
    assign chan_b_wave_out = wave[1];
    assign chan_pin_own_out = own;
    assign chan_pin_oe_out = oe;
    assign irq_out = irq;

    // Checks of pin, register, counting and waveform behaviour
    a_pin_drive: assert property (
        chan_pin_oe_out[1] |-> chan_pin_own_out[1] && $past(chan_dir_in[1]))
        else $error("channel B driver on without ownership or output direction");
    a_ctl_a_resv: assert property (
        (reg_rd_in && reg_addr_in == `TMR8_ADDR_CTL_A) |=> reg_rdata_out[3:2] == 2'h0)
        else $error("control A reserved bits read nonzero");
    a_force_read: assert property (
        (reg_rd_in && reg_addr_in == `TMR8_ADDR_CTL_B) |=> reg_rdata_out[7:4] == 4'h0)
        else $error("force strobes or reserved bits read nonzero");
    a_mask_resv: assert property (
        (reg_rd_in && reg_addr_in == `TMR8_ADDR_MASK) |=> reg_rdata_out[7:3] == 5'h00)
        else $error("mask reserved bits read nonzero");
    a_stop_hold: assert property (
        (cs == `TMR8_CS_STOP && !cnt_wr) |=> cnt == $past(cnt))
        else $error("stopped counter moved");
    a_div8_gap: assert property (
        (cs == `TMR8_CS_DIV8 && tick) |=> (!tick || cs != `TMR8_CS_DIV8) [*7])
        else $error("divide by 8 ticks too close");
    a_ext_rise: assert property (
        (cs == `TMR8_CS_EXT_RISE && !$past(ext_count_in) && ext_count_in && !cnt_wr)
        |=> cnt != $past(cnt))
        else $error("rising external edge did not count");
    a_write_block: assert property (
        (cnt_wr && cs == `TMR8_CS_DIRECT) |=> !match[1] && !match[0])
        else $error("match not blocked after counter write");
    a_flag_b_set: assert property (
        match[1] |=> flags[`TMR8_FLAG_B])
        else $error("match B did not set its flag");
    a_irq_b: assert property (
        (flags[`TMR8_FLAG_B] && mask[`TMR8_FLAG_B] && global_irq_enable_in)
        |=> irq_out[`TMR8_FLAG_B])
        else $error("channel B interrupt not raised");
    a_force_pwm: assert property (
        (force_st[1] && !non_pwm && !tick) |=> chan_b_wave_out == $past(chan_b_wave_out))
        else $error("force acted in a PWM mode");
    a_force_set: assert property (
        (force_st[1] && non_pwm && com[1] == 2'h3 && !wr_ctl_a) |=> chan_b_wave_out)
        else $error("force B did not set the output");
    a_fast_clear: assert property (
        (cls == tmr8_pkg::TMR8_WAVE_FAST && com[1] == 2'h2 && match[1] && !eq_top[1]
         && !wr_ctl_a) |=> !chan_b_wave_out)
        else $error("fast PWM non-inverting did not clear on match");
    a_pc_top_set: assert property (
        (top_ev && eq_top[1] && com[1] == 2'h2 && !wr_ctl_a) |=> chan_b_wave_out)
        else $error("phase-correct special case did not set at TOP");
    a_ctc_clear: assert property (
        (wgm == `TMR8_MODE_CTC && adv && at_top) |=> cnt == `TMR8_BOTTOM)
        else $error("clear on compare A did not wrap the counter");
    a_mode7_ovf: assert property (
        (wgm == `TMR8_MODE_FAST_A && adv && at_top) |=> flags[`TMR8_FLAG_OVF])
        else $error("mode 7 overflow not flagged at TOP");

    c_fast_wrap: cover property (cls == tmr8_pkg::TMR8_WAVE_FAST && bot_ev);
    c_pc_turn: cover property (top_ev ##[1:600] (phase && adv && at_bottom));
    c_ext_tick: cover property (cs == `TMR8_CS_EXT_FALL && tick);
    c_force_b: cover property (force_st[1] && non_pwm && com[1] != 2'h0);
endmodule

// file: include/tmr8_consts.svh
/*
 Offsets, field positions, reset values and prescaler taps of the 8-bit timer.
 Assumes it is included by bare name and that the register port is 8 bits wide.
*/
// Overview of operation
// - Nonzero channel B action takes over the pin; driver enabled only when direction is output.
// - Non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM channel B: 10 clear on match, set at bottom; 11 inverse; 01 reserved.
// - Fast PWM with compare B at TOP and upper bit set: match ignored, act at bottom.
// - Phase-correct channel B: 10 clears counting up, sets counting down; 11 inverse.
// - Phase-correct with compare B at TOP and upper bit set: match ignored, act at TOP.
// - Control A bits 3:2 always read zero.
// - Waveform mode is the control B high bit above the two control A bits.
// - Modes 0..3: normal, phase-correct, clear on compare A, fast PWM, as tabulated.
// - Mode 5 phase-correct and mode 7 fast PWM take TOP from compare A.
// - Force strobes act only in non-PWM modes; software writes them zero otherwise.
// - Force A applies channel A action now; no flag, no counter clear; reads zero.
// - Force B applies channel B action now; no flag, no counter clear; reads zero.
// - Clock select 0 stops; 1 direct; 2..5 divide by 8, 64, 256, 1024.
// - Clock select 6 counts falling and 7 rising edges of the external input.
// - External edges count even when that pin is an output.
// - Counter is read and written directly; a write blocks the next tick's match.
// - Compare A is compared always; match sets its flag and drives channel A.
// - Compare B is compared always; match sets its flag and drives channel B.
// - Mask bit 2 with global enable and flag B raises interrupt; bits 7:3 read zero.
// - Match flag B sets on match; cleared by vector or writing one.
// - Overflow flag sets where the mode says; cleared by vector or writing one.
`ifndef TMR8_CONSTS_SVH
`define TMR8_CONSTS_SVH
`define TMR8_ADDR_CTL_A 8'h24
`define TMR8_ADDR_CTL_B 8'h25
`define TMR8_ADDR_COUNT 8'h26
`define TMR8_ADDR_CMP_A 8'h27
`define TMR8_ADDR_CMP_B 8'h28
`define TMR8_ADDR_MASK 8'h29
`define TMR8_ADDR_FLAGS 8'h2a
`define TMR8_COM_A_LSB 6
`define TMR8_COM_B_LSB 4
`define TMR8_FORCE_A_BIT 7
`define TMR8_FORCE_B_BIT 6
`define TMR8_WGM_HI_BIT 3
`define TMR8_FLAG_OVF 0
`define TMR8_FLAG_A 1
`define TMR8_FLAG_B 2
`define TMR8_RESET_BYTE 8'h00
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00
`define TMR8_MODE_CTC 3'h2
`define TMR8_MODE_PC_A 3'h5
`define TMR8_MODE_FAST_A 3'h7
`define TMR8_CS_STOP 3'h0
`define TMR8_CS_DIRECT 3'h1
`define TMR8_CS_DIV8 3'h2
`define TMR8_CS_DIV64 3'h3
`define TMR8_CS_DIV256 3'h4
`define TMR8_CS_DIV1024 3'h5
`define TMR8_CS_EXT_FALL 3'h6
`define TMR8_CS_EXT_RISE 3'h7
`define TMR8_PRESC_WIDTH 10
`define TMR8_DIV8_LOG 3
`define TMR8_DIV64_LOG 6
`define TMR8_DIV256_LOG 8
`define TMR8_DIV1024_LOG 10
`endif

// file: include/tmr8_pkg.sv
/*
 Types shared by the 8-bit timer modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tmr8_pkg;
    // Family of the waveform mode, which picks the output action table
    typedef enum logic [1:0] {
        TMR8_WAVE_NONPWM,
        TMR8_WAVE_FAST,
        TMR8_WAVE_PHASE
    } tmr8_wave_class_type;
endpackage

// file: include/tmr8_tick_if.sv
/*
 Carrier of the prescaler tap pulses from the prescaler to the timer core.
 Assumes both ends run on the same clock.
*/
interface tmr8_tick_if;
    logic [3:0] tap;
    modport src (output tap);
    modport dst (input tap);
endinterface

// file: hw/tmr8_prescaler.sv
/*
 Free-running prescaler giving one-cycle pulses at clock/8, /64, /256 and /1024.
 Assumes a synchronous active-high reset and the constants header.
*/
`include "tmr8_consts.svh"
module tmr8_prescaler #(
    parameter int WIDTH = `TMR8_PRESC_WIDTH
) (
    input wire logic clock_in,
    input wire logic srst_in,
    tmr8_tick_if.src tick_bus
);
    localparam int TAP_LOG [4] = '{`TMR8_DIV8_LOG, `TMR8_DIV64_LOG,
                                   `TMR8_DIV256_LOG, `TMR8_DIV1024_LOG};
    logic [WIDTH-1:0] count;
    logic [3:0] tap_q;
    logic [3:0] next_tap;

    // Each tap fires when its low counter bits are all ones
    for (genvar i = 0; i < 4; i++) begin : g_tap
        assign next_tap[i] = &count[TAP_LOG[i]-1:0];
    end

    // Divider chain and registered pulses
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            count <= '0;
            tap_q <= 4'h0;
        end else begin
            count <= count + WIDTH'(1);
            tap_q <= next_tap;
        end
    end

    assign tick_bus.tap = tap_q;
endmodule

// file: tb/tb_tmr8_timer.sv
/*
 Self-checking bench for the 8-bit timer: registers, force strobes, matches, PWM, clocks.
 Assumes the register map of the constants header and a 200 MHz clock.
*/
`include "tmr8_consts.svh"
module tb_tmr8_timer;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic ext_count_in = 1'b0;
    logic global_irq_enable_in = 1'b0;
    logic [2:0] irq_ack_in = 3'h0;
    logic [1:0] chan_dir_in = 2'h0;
    logic [7:0] reg_rdata_out;
    logic chan_a_wave_out;
    logic chan_b_wave_out;
    logic [1:0] chan_pin_own_out;
    logic [1:0] chan_pin_oe_out;
    logic [2:0] irq_out;
    logic [7:0] rv;
    int bad_count = 0;
    int samples_checked = 0;
    tmr8_timer u_tmr8_timer (.clock_in(clock_in), .srst_in(srst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ext_count_in(ext_count_in),
        .global_irq_enable_in(global_irq_enable_in), .irq_ack_in(irq_ack_in),
        .chan_dir_in(chan_dir_in), .chan_a_wave_out(chan_a_wave_out),
        .chan_b_wave_out(chan_b_wave_out), .chan_pin_own_out(chan_pin_own_out),
        .chan_pin_oe_out(chan_pin_oe_out), .irq_out(irq_out));
    // Clock of 5 ns period
    always #2.5 clock_in = ~clock_in;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        @(negedge clock_in);
        d = reg_rdata_out;
        // End on a rising edge so that callers drive inputs right after it
        @(posedge clock_in);
    endtask
    task automatic rst;
        @(posedge clock_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
    endtask
    task automatic t_regs;
        for (int a = 8'h24; a <= 8'h2a; a++) begin
            rd(8'(a), rv);
            chk(rv, 8'h00);
        end
        wr(8'h20, 8'hff);
        rd(8'h20, rv);
        chk(rv, 8'h00);
        wr(8'h24, 8'hff);
        rd(8'h24, rv);
        chk(rv, 8'hf3);
        wr(8'h25, 8'hc8);
        rd(8'h25, rv);
        chk(rv, 8'h08);
        wr(8'h29, 8'hff);
        rd(8'h29, rv);
        chk(rv, 8'h07);
        wr(8'h26, 8'h5a);
        rd(8'h26, rv);
        chk(rv, 8'h5a);
        wr(8'h27, 8'ha5);
        rd(8'h27, rv);
        chk(rv, 8'ha5);
        wr(8'h28, 8'h3c);
        rd(8'h28, rv);
        chk(rv, 8'h3c);
        rst();
    endtask
    // Force strobe walks every action code, then must be ignored in fast PWM
    task automatic t_force;
        logic [1:0] code [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
        logic want [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        chan_dir_in <= 2'h2;
        for (int i = 0; i < 5; i++) begin
            wr(8'h24, {code[i], code[i], 4'h0});
            wr(8'h25, 8'hc0);
            repeat (2) @(posedge clock_in);
            chk(8'(chan_b_wave_out), 8'(want[i]));
            chk(8'(chan_a_wave_out), 8'(want[i]));
            chk(8'(chan_pin_own_out), code[i] != 2'h0 ? 8'h03 : 8'h00);
            chk(8'(chan_pin_oe_out), code[i] != 2'h0 ? 8'h02 : 8'h00);
        end
        rd(8'h2a, rv);
        chk(rv, 8'h00);
        chan_dir_in <= 2'h0;
        wr(8'h24, 8'h13);
        wr(8'h25, 8'h40);
        repeat (2) @(posedge clock_in);
        chk(8'(chan_b_wave_out), 8'h00);
        chk(8'(chan_pin_oe_out[1]), 8'h00);
        rst();
    endtask
    task automatic t_match;
        wr(8'h28, 8'h05);
        wr(8'h24, 8'h10);
        wr(8'h29, 8'h04);
        global_irq_enable_in <= 1'b1;
        wr(8'h25, 8'h01);
        repeat (10) @(posedge clock_in);
        chk(8'(chan_b_wave_out), 8'h01);
        chk(8'(irq_out), 8'h04);
        rd(8'h2a, rv);
        chk(rv & 8'h04, 8'h04);
        wr(8'h2a, 8'h04);
        rd(8'h2a, rv);
        chk(rv & 8'h04, 8'h00);
        chk(8'(irq_out), 8'h00);
        wr(8'h26, 8'h05);
        repeat (5) @(posedge clock_in);
        rd(8'h2a, rv);
        chk(rv & 8'h04, 8'h00);
        wr(8'h26, 8'hfd);
        repeat (6) @(posedge clock_in);
        rd(8'h2a, rv);
        chk(rv & 8'h01, 8'h01);
        irq_ack_in <= 3'h1;
        @(posedge clock_in);
        irq_ack_in <= 3'h0;
        rd(8'h2a, rv);
        chk(rv & 8'h01, 8'h00);
        global_irq_enable_in <= 1'b0;
        rst();
    endtask
    // High time of channel B over 512 cycles in each PWM, mode 5 and CTC setting
    task automatic t_pwm;
        logic [7:0] ca [9] = '{8'h23, 8'h33, 8'h21, 8'h31, 8'h23, 8'h21, 8'h23, 8'h21, 8'h12};
        logic [7:0] cb [9] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h09, 8'h09, 8'h01};
        logic [7:0] oc [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h40, 8'h40, 8'h20, 8'h20, 8'h20};
        int lo [9] = '{512, 0, 512, 0, 128, 126, 128, 128, 256};
        int hi [9] = '{512, 0, 512, 0, 132, 132, 136, 132, 256};
        int h;
        for (int i = 0; i < 9; i++) begin
            h = 0;
            wr(8'h27, 8'h7f);
            wr(8'h28, oc[i]);
            wr(8'h24, ca[i]);
            wr(8'h25, cb[i]);
            repeat (600) @(posedge clock_in);
            repeat (512) begin
                @(negedge clock_in);
                if (chan_b_wave_out === 1'b1) h++;
            end
            chk(8'(h >= lo[i] && h <= hi[i]), 8'h01);
            rst();
        end
    endtask
    task automatic t_clk;
        int dv [6] = '{1, 1, 8, 64, 256, 1024};
        for (int c = 0; c < 6; c++) begin
            wr(8'h25, 8'(c));
            repeat (4 * dv[c]) @(posedge clock_in);
            wr(8'h25, 8'h00);
            rd(8'h26, rv);
            chk(8'(c == 0 ? rv == 8'h00 : rv >= 8'h04 && rv <= 8'h06), 8'h01);
            rst();
        end
        chan_dir_in <= 2'h3;
        for (int c = 6; c < 8; c++) begin
            ext_count_in <= 1'b0;
            wr(8'h25, 8'(c));
            repeat (11) begin
                repeat (2) @(posedge clock_in);
                ext_count_in <= ~ext_count_in;
            end
            repeat (2) @(posedge clock_in);
            wr(8'h25, 8'h00);
            rd(8'h26, rv);
            chk(rv, c == 6 ? 8'h05 : 8'h06);
            rst();
        end
    endtask
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence after a 12-cycle reset
    initial begin
        repeat (12) @(posedge clock_in);
        srst_in <= 1'b0;
        t_regs();
        t_force();
        t_match();
        t_pwm();
        t_clk();
        test_done();
    end
    // Watchdog well beyond the expected run of about 16000 cycles
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule
